// >>> bench/flhc_ctrl_checker.sv
// Purpose: port-level checks of the flash command controller
// Assumes: sees only the ports of the top module
// Notes:   strobe widths follow the twelve-clock bus access
`timescale 1ns/1ns
module flhc_ctrl_checker (
  input wire logic        mclk_i,
  input wire logic        rst_n_i,
  input wire logic [3:0]  sw_addr_i,
  input wire logic        sw_rd_i,
  input wire logic [15:0] sw_rdata_o,
  input wire logic [22:0] fl_addr_o,
  input wire logic [15:0] fl_dq_o,
  input wire logic        fl_dq_oe_o,
  input wire logic        fl_ce_n_o,
  input wire logic        fl_oe_n_o,
  input wire logic        fl_we_n_o
);
  // =========================================================
  // assertions, one clock domain
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!rst_n_i);

  a_reset_idle: assert property ($rose(rst_n_i) |->
    (fl_we_n_o && fl_oe_n_o && !fl_dq_oe_o)[*2])
    else $error("bus not idle after reset");
  a_we_width: assert property ($fell(fl_we_n_o) |->
    !fl_we_n_o[*8] ##1 !fl_we_n_o[*4] ##1 fl_we_n_o)
    else $error("write strobe width wrong");
  a_oe_width: assert property ($fell(fl_oe_n_o) |->
    !fl_oe_n_o[*8] ##1 !fl_oe_n_o[*4] ##1 fl_oe_n_o)
    else $error("read strobe width wrong");
  a_write_hold: assert property (!fl_we_n_o && !$fell(fl_we_n_o)
    |-> $stable(fl_addr_o) && $stable(fl_dq_o))
    else $error("address or data moved in write");
  a_write_drive: assert property (!fl_we_n_o |->
    fl_dq_oe_o && !fl_ce_n_o)
    else $error("write without data drive");
  a_read_release: assert property (!fl_oe_n_o |->
    !fl_dq_oe_o && !fl_ce_n_o && fl_we_n_o)
    else $error("data driven during read");
  a_unmapped_zero: assert property (sw_rd_i && sw_addr_i > 4'h5
    |=> sw_rdata_o == 16'h0000)
    else $error("unmapped read not zero");
  // confirm write must start 13 to 40 clocks after setup
  a_clr_confirm: assert property ($fell(fl_we_n_o) &&
    fl_dq_o[7:0] == 8'h60 |-> ##[13:40]
    ($fell(fl_we_n_o) && fl_dq_o[7:0] == 8'hD0))
    else $error("clear setup not followed by confirm");
  a_otp_space: assert property ($fell(fl_we_n_o) &&
    fl_dq_o[7:0] == 8'hC0 |-> ##[13:40]
    ($fell(fl_we_n_o) && fl_addr_o[22:8] == 15'h0001))
    else $error("protection write outside A8 page");
endmodule // flhc_ctrl_checker

// >>> bench/flhc_flash_model.sv
// Purpose: behavioural flash device facing the controller
// Assumes: a write is taken when the write strobe rises
// Notes:   only lock, protection, buffer and status commands modelled; array reads give 5AA5h
`timescale 1ns/1ns
module flhc_flash_model #(
  parameter logic [15:0] FACTORY = 16'h3C5A // arbitrary value
) (
  input  wire logic                 clk_i,
  input  wire logic                 rst_n_i,
  input  wire flhc_pkg::flhc_pins_s pins_i,
  input  wire logic                 byte_i,
  input  wire logic                 vlow_i,
  input  wire logic                 slow_i,
  output logic [15:0]               dq_o,
  output logic                      ready_o,
  output logic                      locked_o,
  output logic [7:0]                sr_o,
  output logic [4:0]                cnt_o,
  output logic [15:0]               last_o
);
  logic [15:0] otp [0:8]; // lock word then eight words
  logic [7:0]  lkb, sr;
  logic [5:0]  blk, busy, dly, left;
  logic [2:0]  ex;
  logic [1:0]  md;
  logic [15:0] d;
  logic [22:0] a;
  logic [6:0]  w;
  logic        wp;
  assign d = pins_i.dq;
  assign a = pins_i.addr;
  assign w = a[7:1];
  assign dly = slow_i ? 6'h28 : 6'h02;
  assign ready_o = busy == 6'h00;
  assign locked_o = |lkb;
  assign sr_o = sr;
  // a released bus shows the inverse, so stale data never passes
  always_ff @(posedge clk_i)
    if (!pins_i.oe_n && !pins_i.ce_n) dq_o <= md == 2'h1 ?
      {8'h00, sr | {ready_o, 7'h00}} : md == 2'h3 ? 16'h0080 :
      md == 2'h2 ? (byte_i && a[0] ? otp[w] >> 8 : otp[w]) : 16'h5AA5;
    else dq_o <= ~dq_o;
  // command decoder
  always_ff @(posedge clk_i or negedge rst_n_i)
    if (!rst_n_i) begin
      {wp, md, ex, busy, sr, lkb, cnt_o, left, blk, last_o} <= '1;
      {md, ex, busy, sr, cnt_o} <= '0;
      for (int i = 0; i < 9; i++)
        otp[i] <= i == 0 ? 16'hFFFE : i < 5 ? FACTORY ^ 16'(i) : '1;
    end else begin
      wp <= pins_i.we_n | pins_i.ce_n; // strobes are released together
      if (busy != 6'h00) busy <= busy - 6'h01;
      if (pins_i.we_n && !wp) case (ex)
        3'h1: begin
          ex <= 3'h0;
          md <= 2'h1;
          if (d[7:0] != 8'hD0 || busy != 6'h00) sr <= sr | 8'h30;
          else if (vlow_i) sr <= sr | 8'h28;
          else begin lkb <= '0; busy <= dly; end
        end
        3'h2: begin
          ex <= 3'h0;
          md <= 2'h1;
          busy <= dly;
          if (a[22:8] != 15'h0001 || w > 7'h08 || (byte_i && a[7:0] == 8'h01))
            sr <= sr | 8'h10;
          else if (w != 7'h00 && !otp[0][w > 7'h04]) sr <= sr | 8'h12;
          else if (!byte_i) otp[w] <= otp[w] & d;
          else if (a[0]) otp[w][15:8] <= otp[w][15:8] & d[7:0];
          else otp[w][7:0] <= otp[w][7:0] & d[7:0];
        end
        3'h3: begin
          md <= 2'h1;
          cnt_o <= d[4:0];
          left <= {1'b0, d[4:0]} + 6'h01;
          ex <= d[7:0] > (byte_i ? 8'h1F : 8'h0F) ? 3'h0 : 3'h4;
        end
        3'h4: if (a[22:17] != blk) begin sr <= sr | 8'h30; ex <= 3'h0; end
          else begin
            last_o <= d;
            left <= left - 6'h01;
            if (left == 6'h01) ex <= 3'h5;
          end
        3'h5: begin
          ex <= 3'h0;
          if (d[7:0] == 8'hD0) busy <= dly; else sr <= sr | 8'h30;
        end
        default: case (d[7:0])
          8'h60: ex <= 3'h1;
          8'h90: md <= 2'h2;
          8'hFF: md <= 2'h0;
          8'hC0: ex <= 3'h2;
          8'h70: md <= 2'h1;
          8'h50: sr <= 8'h00;
          8'hE8: begin md <= 2'h3; ex <= 3'h3; blk <= a[22:17]; end
          default: ;
        endcase
      endcase
    end
endmodule // flhc_flash_model

// >>> bench/test_flhc_ctrl.sv
// Purpose: self-checking bench for the flash command controller
// Assumes: software strobes change right after rising edges
// Notes:   random data has bit 0 set so it never mimics a command other than FFh
`timescale 1ns/1ns
module test_flhc_ctrl;
  localparam logic [15:0] FACT = 16'h3C5A; // arbitrary value
  logic mclk_i = 1'h0, rst_n_i = 1'h0, sw_wr_i = 1'h0, sw_rd_i = 1'h0;
  logic byt = 1'h0, vlow = 1'h0, slow = 1'h0, lkd, pin, dqoe, ce, oe, we;
  logic [3:0] sw_addr_i = 4'h0;
  logic [15:0] sw_wdata_i = 16'h0000, rdat, dqi, dqo, v, e, p, last;
  logic [22:0] adr;
  logic [7:0] sr;
  logic [4:0] cnt;
  logic [31:0] lfsr = 32'h6BC5;
  int num_errors = 0, comparisons = 0, n;
  initial forever #5 mclk_i = ~mclk_i;
  flhc_ctrl u_flhc_ctrl (.mclk_i, .rst_n_i, .sw_addr_i, .sw_wdata_i,
    .sw_wr_i, .sw_rd_i, .sw_rdata_o(rdat), .fl_dq_i(dqi),
    .fl_status_output_pin_i(pin), .fl_addr_o(adr), .fl_dq_o(dqo),
    .fl_dq_oe_o(dqoe), .fl_ce_n_o(ce), .fl_oe_n_o(oe), .fl_we_n_o(we));
  flhc_flash_model #(.FACTORY(FACT)) u_flhc_flash_model (.clk_i(mclk_i),
    .rst_n_i, .pins_i({adr, dqo, dqoe, ce, oe, we}), .byte_i(byt),
    .vlow_i(vlow), .slow_i(slow), .dq_o(dqi), .ready_o(pin),
    .locked_o(lkd), .sr_o(sr), .cnt_o(cnt), .last_o(last));
  function automatic logic [15:0] rnd();
    lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
    return lfsr[15:0] | 16'h0001;
  endfunction
  // word k sits k+1 places above the lock word, on A7..A1
  function automatic logic [15:0] woff(int k);
    return 16'((k + 1) * 2);
  endfunction
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge mclk_i);
    sw_addr_i <= a;
    sw_wdata_i <= d;
    sw_wr_i <= 1'h1;
    @(posedge mclk_i);
    sw_wr_i <= 1'h0;
  endtask
  task automatic rd(input logic [3:0] a, output logic [15:0] d);
    @(posedge mclk_i);
    sw_addr_i <= a;
    sw_rd_i <= 1'h1;
    @(posedge mclk_i);
    sw_rd_i <= 1'h0;
    #1 d = rdat;
  endtask
  task automatic chk(input string s, input logic [15:0] x, y);
    comparisons++;
    if (x !== y) begin
      num_errors++;
      $display("CHECK FAILED %s expected %h seen %h", s, x, y);
    end
  endtask
  task automatic run(input logic [2:0] op);
    int i; // own counter: n carries the buffer word count
    wr(flhc_pkg::REG_CTRL, {7'h00, 1'h1, 5'h00, op});
    for (i = 0; i < 3000; i++) begin
      rd(flhc_pkg::REG_CTRL, v);
      if (v[0] === 1'h0) break;
    end
    if (i == 3000) begin num_errors++; final_report(); end
  endtask
  task automatic stat(input logic [15:0] x);
    rd(flhc_pkg::REG_STAT, v);
    chk("status", x, v & 16'h00FF);
  endtask
  task automatic final_report();
    $display("comparisons %0d mismatches %0d", comparisons, num_errors);
    if (num_errors == 0 && comparisons > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  initial begin
    repeat (6) @(posedge mclk_i);
    rst_n_i <= 1'h1;
    repeat (3) @(posedge mclk_i);
    // low supply and slow device: locks kept, errors cleared after
    vlow <= 1'h1;
    slow <= 1'h1;
    run(flhc_pkg::OP_CLRLOCK);
    chk("error bit", 16'h0002, v & 16'h0002);
    stat(16'h00A8);
    chk("flags cleared", 16'h0000, {8'h00, sr & 8'h3A});
    chk("locks kept", 16'h0001, {15'h0000, lkd});
    vlow <= 1'h0;
    run(flhc_pkg::OP_CLRLOCK);
    chk("locks gone", 16'h0000, {15'h0000, lkd});
    stat(16'h0080);
    $display("clear lock tests done");
    slow <= 1'h0;
    wr(flhc_pkg::REG_MODE, 16'h0000);
    for (int k = 3; k < 8; k++) begin
      e = k == 3 ? FACT ^ 16'h0004 : rnd();
      wr(flhc_pkg::REG_ADDR, woff(k));
      wr(flhc_pkg::REG_DATA, e);
      if (k > 3) run(flhc_pkg::OP_OTPPROG);
      run(flhc_pkg::OP_IDREAD);
      rd(flhc_pkg::REG_DATA, v);
      chk("otp word", e, v);
    end
    byt <= 1'h1;
    wr(flhc_pkg::REG_MODE, 16'h0001);
    wr(flhc_pkg::REG_ADDR, 16'h0011); // last user byte, high half
    p = e; // word 7 as programmed above; otp bits only clear
    e = rnd();
    wr(flhc_pkg::REG_DATA, e);
    run(flhc_pkg::OP_OTPPROG);
    run(flhc_pkg::OP_IDREAD);
    rd(flhc_pkg::REG_DATA, v);
    chk("otp byte", {8'h00, p[15:8] & e[7:0]}, v & 16'h00FF);
    byt <= 1'h0;
    wr(flhc_pkg::REG_MODE, 16'h0000);
    wr(flhc_pkg::REG_ADDR, 16'h0020);
    run(flhc_pkg::OP_OTPPROG);
    stat(16'h0090);
    wr(flhc_pkg::REG_ADDR, 16'h0000);
    wr(flhc_pkg::REG_DATA, 16'hFFFD);
    run(flhc_pkg::OP_OTPPROG);
    wr(flhc_pkg::REG_ADDR, woff(4));
    run(flhc_pkg::OP_OTPPROG);
    stat(16'h0092);
    $display("protection tests done");
    for (int t = 0; t < 4; t++) begin
      n = t == 0 ? 16 : int'(rnd() & 16'h0003) + 1;
      wr(flhc_pkg::REG_ADDR, rnd());
      for (int i = 0; i < n; i++) begin e = rnd(); wr(flhc_pkg::REG_PUSH, e); end
      run(flhc_pkg::OP_BUFPROG);
      chk("count", 16'(n - 1), {11'h000, cnt});
      chk("last data", e, last);
      stat(16'h0080);
    end
    rd(4'hF, v);
    chk("unmapped", 16'h0000, v);
    $display("buffer tests done");
    final_report();
  end
endmodule // test_flhc_ctrl

bind flhc_ctrl flhc_ctrl_checker u_flhc_ctrl_checker (.mclk_i, .rst_n_i,
  .sw_addr_i, .sw_rd_i, .sw_rdata_o, .fl_addr_o, .fl_dq_o, .fl_dq_oe_o,
  .fl_ce_n_o, .fl_oe_n_o, .fl_we_n_o);

// >>> rtl/flhc_ctrl.sv
// Purpose: host-side sequencer for flash lock, otp and buffer commands
// Assumes: pins synchronous to mclk_i, device status pin high = ready
// Notes:   one bus cycle is ACC_CYC clocks of strobe plus one idle
//
// Strobed register access and the placing of the registers were left to the implementer.
`timescale 1ns/1ns
module flhc_ctrl (
  input  wire logic        mclk_i,
  input  wire logic        rst_n_i,
  input  wire logic [3:0]  sw_addr_i,
  input  wire logic [15:0] sw_wdata_i,
  input  wire logic        sw_wr_i,
  input  wire logic        sw_rd_i,
  output logic [15:0]      sw_rdata_o,
  input  wire logic [15:0] fl_dq_i,
  input  wire logic        fl_status_output_pin_i,
  output logic [22:0]      fl_addr_o,
  output logic [15:0]      fl_dq_o,
  output logic             fl_dq_oe_o,
  output logic             fl_ce_n_o,
  output logic             fl_oe_n_o,
  output logic             fl_we_n_o
);
  typedef enum logic [7:0] {
    S_IDLE = 8'h01, S_CMD  = 8'h02, S_AVAIL = 8'h04, S_COUNT = 8'h08,
    S_DATA = 8'h10, S_WAIT = 8'h20, S_POLL  = 8'h40, S_CLR   = 8'h80
  } flhc_state_e;

  typedef struct packed {
    flhc_state_e       st;
    flhc_pkg::flhc_pins_s pin;
    logic [1:0]        rst_sync;
    logic [3:0]        tmr;
    logic              rd;          // current bus cycle is a read
    logic [1:0]        step;        // which write of a sequence
    logic [2:0]        op;
    logic [22:0]       addr;
    logic [15:0]       data;
    logic [15:0]       rdata;       // last ID or extended status read
    logic [7:0]        status;
    logic              err;
    logic              byte_mode;
    logic [4:0]        cnt;         // buffer count N
    logic [4:0]        wr_ptr;
    logic [4:0]        rd_ptr;
    logic [15:0]       sw_rdata;
  } flhc_state_s;

  flhc_state_s cur_ff;
  flhc_state_s nxt_cur;
  logic [15:0] buf_mem [flhc_pkg::BUF_DEPTH];
  logic        rst_n;

  // a bus cycle: drive strobes for ACC_CYC clocks then release one clock
  function automatic logic [3:0] tick(input logic [3:0] t);
    return (t == flhc_pkg::ACC_CYC) ? 4'h0 : t + 4'h1;
  endfunction

  // block base address: 128 KB blocks, lower 17 bits cleared
  function automatic logic [22:0] blk(input logic [22:0] a);
    return {a[22:17], 17'h00000};
  endfunction

  assign rst_n = cur_ff.rst_sync[1];

  // buffer data array, written by software only
  always_ff @(posedge mclk_i) begin
    if (sw_wr_i && sw_addr_i == flhc_pkg::REG_PUSH) begin
      buf_mem[cur_ff.wr_ptr] <= sw_wdata_i;
    end
  end

  // =========================================================
  // next state
  always_comb begin
    logic done;
    logic [7:0] cmd;
    nxt_cur = cur_ff;
    done = (cur_ff.tmr == flhc_pkg::ACC_CYC);
    cmd = 8'h00;
    nxt_cur.rst_sync = {cur_ff.rst_sync[0], 1'b1};
    nxt_cur.pin.ce_n = 1'b1;
    nxt_cur.pin.oe_n = 1'b1;
    nxt_cur.pin.we_n = 1'b1;
    nxt_cur.pin.dq_oe = 1'b0;
    // software port; register reads answer next cycle
    if (sw_wr_i) begin
      unique case (sw_addr_i)
        flhc_pkg::REG_ADDR: nxt_cur.addr = {7'h00, sw_wdata_i};
        flhc_pkg::REG_DATA: nxt_cur.data = sw_wdata_i;
        flhc_pkg::REG_MODE: nxt_cur.byte_mode = sw_wdata_i[0];
        flhc_pkg::REG_PUSH: nxt_cur.wr_ptr = cur_ff.wr_ptr + 5'h01;
        flhc_pkg::REG_CTRL: begin
          if (sw_wdata_i[flhc_pkg::CTRL_GO_BIT] && cur_ff.st == S_IDLE) begin
            nxt_cur.op = sw_wdata_i[2:0];
            nxt_cur.st = S_CMD;
            nxt_cur.step = 2'h0;
            nxt_cur.tmr = 4'h0;
            nxt_cur.rd = 1'b0; // a poll leaves rd set; first cycle writes
            nxt_cur.err = 1'b0;
          end
        end
        default: ;
      endcase
    end
    if (sw_rd_i) begin
      unique case (sw_addr_i)
        flhc_pkg::REG_CTRL: nxt_cur.sw_rdata =
          {14'h0000, cur_ff.err, cur_ff.st != S_IDLE};
        flhc_pkg::REG_STAT: nxt_cur.sw_rdata = {8'h00, cur_ff.status};
        flhc_pkg::REG_DATA: nxt_cur.sw_rdata = cur_ff.rdata;
        flhc_pkg::REG_MODE: nxt_cur.sw_rdata = {15'h0000, cur_ff.byte_mode};
        default:            nxt_cur.sw_rdata = 16'h0000;
      endcase
    end
    // drive a bus cycle while timer runs below ACC_CYC
    if (cur_ff.st != S_IDLE && cur_ff.st != S_WAIT && !done) begin
      nxt_cur.pin.ce_n = 1'b0;
      nxt_cur.pin.we_n = cur_ff.rd;
      nxt_cur.pin.oe_n = !cur_ff.rd;
      nxt_cur.pin.dq_oe = !cur_ff.rd;
    end
    unique case (cur_ff.st)
      S_IDLE: nxt_cur.tmr = 4'h0;
      // command writes per operation
      S_CMD: begin
        nxt_cur.rd = 1'b0;
        nxt_cur.tmr = tick(cur_ff.tmr);
        unique case (cur_ff.op)
          flhc_pkg::OP_CLRLOCK: begin
            cmd = (cur_ff.step == 2'h0) ? flhc_pkg::CMD_CLR_SETUP
                                        : flhc_pkg::CMD_CONFIRM;
            nxt_cur.pin.addr = 23'h000000;
            nxt_cur.pin.dq = {8'h00, cmd};
          end
          flhc_pkg::OP_OTPPROG: begin
            nxt_cur.pin.addr = (cur_ff.step == 2'h0) ? flhc_pkg::OTP_BASE
              : {14'h0000, 1'b1, cur_ff.addr[7:0]};
            nxt_cur.pin.dq = (cur_ff.step == 2'h0)
              ? {8'h00, flhc_pkg::CMD_OTP_SETUP}
              : (cur_ff.byte_mode ? {8'h00, cur_ff.data[7:0]}
                                  : cur_ff.data); // FFFDh locks user
          end
          flhc_pkg::OP_IDREAD: begin
            nxt_cur.pin.addr = flhc_pkg::OTP_BASE;
            nxt_cur.pin.dq = {8'h00, flhc_pkg::CMD_READ_ID};
          end
          flhc_pkg::OP_BUFPROG: begin
            nxt_cur.pin.addr = blk(cur_ff.addr);
            nxt_cur.pin.dq = {8'h00, flhc_pkg::CMD_BUF_WRITE};
          end
          default: begin
            nxt_cur.pin.addr = 23'h000000;
            nxt_cur.pin.dq = {8'h00, flhc_pkg::CMD_ARRAY};
          end
        endcase
        if (done) begin
          nxt_cur.step = cur_ff.step + 2'h1;
          if (cur_ff.op == flhc_pkg::OP_BUFPROG ||
              cur_ff.op == flhc_pkg::OP_IDREAD) begin
            nxt_cur.st = S_AVAIL;
            nxt_cur.rd = 1'b1;
          end else if ((cur_ff.op == flhc_pkg::OP_CLRLOCK ||
                        cur_ff.op == flhc_pkg::OP_OTPPROG) &&
                       cur_ff.step == 2'h0) begin
            nxt_cur.st = S_CMD;
          end else if (cur_ff.op == flhc_pkg::OP_CLRLOCK ||
                       cur_ff.op == flhc_pkg::OP_OTPPROG) begin
            nxt_cur.st = S_WAIT;
          end else begin
            nxt_cur.st = S_IDLE;
          end
        end
      end
      // one read: a protection location after 90h, else extended status
      S_AVAIL: begin
        nxt_cur.tmr = tick(cur_ff.tmr);
        nxt_cur.pin.addr = (cur_ff.op == flhc_pkg::OP_IDREAD)
          ? {14'h0000, 1'b1, cur_ff.addr[7:0]}
          : blk(cur_ff.addr);
        if (done) begin
          nxt_cur.rdata = fl_dq_i;
          nxt_cur.rd = 1'b0;
          if (cur_ff.op == flhc_pkg::OP_IDREAD) begin
            nxt_cur.st = S_IDLE;
          end else if (fl_dq_i[flhc_pkg::XSR_BUF_AVAIL]) begin
            nxt_cur.st = S_COUNT;
            nxt_cur.cnt = (cur_ff.wr_ptr == 5'h00) ? 5'h00
                                                   : cur_ff.wr_ptr - 5'h01;
            // clip here so the count stands unchanged through its write
            if (!cur_ff.byte_mode &&
                nxt_cur.cnt > flhc_pkg::CNT_MAX_WORD) begin
              nxt_cur.cnt = flhc_pkg::CNT_MAX_WORD;
            end
          end else begin
            nxt_cur.st = S_CMD;
          end
        end
      end
      // count write, clipped to the mode limit
      S_COUNT: begin
        nxt_cur.pin.addr = blk(cur_ff.addr);
        nxt_cur.pin.dq = {11'h000, cur_ff.cnt};
        nxt_cur.tmr = tick(cur_ff.tmr);
        nxt_cur.rd_ptr = 5'h00;
        if (done) nxt_cur.st = S_DATA;
      end
      // exactly N+1 data writes inside the block, then confirm
      S_DATA: begin
        nxt_cur.tmr = tick(cur_ff.tmr);
        if (cur_ff.rd_ptr > cur_ff.cnt) begin
          nxt_cur.pin.addr = blk(cur_ff.addr);
          nxt_cur.pin.dq = {8'h00, flhc_pkg::CMD_CONFIRM};
          if (done) nxt_cur.st = S_WAIT;
        end else begin
          nxt_cur.pin.addr = cur_ff.addr + {18'h00000, cur_ff.rd_ptr};
          nxt_cur.pin.dq = buf_mem[cur_ff.rd_ptr];
          if (done) nxt_cur.rd_ptr = cur_ff.rd_ptr + 5'h01;
        end
      end
      // wait for the status pin to report ready
      S_WAIT: begin
        nxt_cur.tmr = 4'h0;
        nxt_cur.rd = 1'b1;
        if (fl_status_output_pin_i) nxt_cur.st = S_POLL;
      end
      // status read; an OE low-high-low cycle refreshes it
      S_POLL: begin
        nxt_cur.tmr = tick(cur_ff.tmr);
        if (done) begin
          nxt_cur.status = fl_dq_i[7:0];
          nxt_cur.wr_ptr = 5'h00;
          if (!fl_dq_i[flhc_pkg::SR_READY]) begin
            nxt_cur.st = S_POLL;
          end else if (fl_dq_i[flhc_pkg::SR_ERASE_ERR] ||
                       fl_dq_i[flhc_pkg::SR_PROG_ERR] ||
                       fl_dq_i[flhc_pkg::SR_VOLT_ERR] ||
                       fl_dq_i[flhc_pkg::SR_LOCK_ERR]) begin
            nxt_cur.err = 1'b1; // software repeats clear-lock
            nxt_cur.rd = 1'b0;
            nxt_cur.st = S_CLR;
          end else begin
            nxt_cur.st = S_IDLE;
          end
        end
      end
      // clear status after any error
      S_CLR: begin
        nxt_cur.pin.dq = {8'h00, flhc_pkg::CMD_CLR_STAT};
        nxt_cur.tmr = tick(cur_ff.tmr);
        if (done) nxt_cur.st = S_IDLE;
      end
    endcase
  end

  // state register; reset loads constants, except rst_sync, which keeps shifting during the synchronised reset
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cur_ff <= '{st: S_IDLE, pin: '{addr: 23'h000000, dq: 16'h0000,
                  dq_oe: 1'b0, ce_n: 1'b1, oe_n: 1'b1, we_n: 1'b1},
                  default: '0};
    end else if (!rst_n) begin
      cur_ff <= '{st: S_IDLE, pin: '{addr: 23'h000000, dq: 16'h0000,
                  dq_oe: 1'b0, ce_n: 1'b1, oe_n: 1'b1, we_n: 1'b1},
                  rst_sync: nxt_cur.rst_sync, default: '0};
    end else begin
      cur_ff <= nxt_cur;
    end
  end

  assign sw_rdata_o = cur_ff.sw_rdata;
  assign fl_addr_o  = cur_ff.pin.addr;
  assign fl_dq_o    = cur_ff.pin.dq;
  assign fl_dq_oe_o = cur_ff.pin.dq_oe;
  assign fl_ce_n_o  = cur_ff.pin.ce_n;
  assign fl_oe_n_o  = cur_ff.pin.oe_n;
  assign fl_we_n_o  = cur_ff.pin.we_n;
endmodule // flhc_ctrl

// >>> rtl/flhc_pkg.sv
// Purpose: constants and carriers for the flash command controller
// Assumes: one 100 MHz clock, parallel flash on plain pins
// Notes:   numbers used by the controller live here, except the 128 KB block size and the otp A8 bit
package flhc_pkg;
  // =========================================================
  // software port
  localparam logic [3:0]  REG_CTRL      = 4'h0; // w: cmd start, r: state
  localparam logic [3:0]  REG_ADDR      = 4'h1;
  localparam logic [3:0]  REG_DATA      = 4'h2;
  localparam logic [3:0]  REG_STAT      = 4'h3; // r: last status
  localparam logic [3:0]  REG_PUSH      = 4'h4; // w: buffer data word
  localparam logic [3:0]  REG_MODE      = 4'h5; // bit0: byte mode
  localparam int          CTRL_GO_BIT   = 8;
  localparam int          CTRL_BUSY_BIT = 0;
  localparam int          CTRL_ERR_BIT  = 1;
  // =========================================================
  // op codes chosen by software in CTRL[2:0]
  localparam logic [2:0]  OP_CLRLOCK    = 3'h1;
  localparam logic [2:0]  OP_IDREAD     = 3'h2;
  localparam logic [2:0]  OP_OTPPROG    = 3'h3;
  localparam logic [2:0]  OP_BUFPROG    = 3'h4;
  localparam logic [2:0]  OP_ARRAY      = 3'h5;
  // =========================================================
  // device commands
  localparam logic [7:0]  CMD_CLR_SETUP = 8'h60;
  localparam logic [7:0]  CMD_CONFIRM   = 8'hD0;
  localparam logic [7:0]  CMD_READ_ID   = 8'h90;
  localparam logic [7:0]  CMD_ARRAY     = 8'hFF;
  localparam logic [7:0]  CMD_OTP_SETUP = 8'hC0;
  localparam logic [7:0]  CMD_BUF_WRITE = 8'hE8;
  localparam logic [7:0]  CMD_CLR_STAT  = 8'h50;
  localparam logic [15:0] OTP_USER_LOCK = 16'hFFFD;
  localparam logic [22:0] OTP_BASE      = 23'h000100; // A8=1
  // =========================================================
  // status bit positions
  localparam int          SR_READY      = 7;
  localparam int          SR_ERASE_ERR  = 5;
  localparam int          SR_PROG_ERR   = 4;
  localparam int          SR_VOLT_ERR   = 3;
  localparam int          SR_LOCK_ERR   = 1;
  localparam int          XSR_BUF_AVAIL = 7;
  localparam logic [4:0]  CNT_MAX_BYTE  = 5'h1F;
  localparam logic [4:0]  CNT_MAX_WORD  = 5'h0F;
  // =========================================================
  // bus timing: 120 ns access, rounded up at 10 ns
  localparam int          T_ACC_NS      = 120;
  localparam int          CLK_NS        = 10;
  localparam logic [3:0]  ACC_CYC       = 4'((T_ACC_NS+CLK_NS-1)/CLK_NS);
  localparam int          BUF_DEPTH     = 32;

  typedef struct packed {
    logic [22:0] addr;
    logic [15:0] dq;
    logic        dq_oe;
    logic        ce_n;
    logic        oe_n;
    logic        we_n;
  } flhc_pins_s;
endpackage
